// ### rtl/scm_core.sv
// command execution core of a small single-wire serial memory
// assumes a framer delivering command bytes, ack events and standby pulses
`timescale 1ns/10ps
`default_nettype none
module scm_core
  import scm_pkg::*;
#(
  parameter int PROG_CYC = PROG_CYCLES
) (
  input  wire logic         clock,
  input  wire logic         rst_b,
  input  wire logic         cmdStart,
  input  wire scm_byte_type rxByte,
  input  wire scm_ack_type  ackIn,
  output scm_byte_type      txByte,
  output logic              sakOut,
  output logic              muteOut,
  output logic [7:0]        statusOut
);
  // ****************************************************
  // storage and state
  // ****************************************************
  logic [7:0]           mem [2**ADDR_W];
  logic [ADDR_W-1:0]    addrCount;
  logic [7:0]           rxData;
  logic [7:0]           cmdReg;
  logic                 writeLatch;
  logic [1:0]           protectLevel = PROT_INIT; // nonvolatile, kept across rst_b
  logic                 progIsPage;
  logic [3:0]           pageBase;
  scm_state_type        state;
  scm_state_type        next_state;
  logic                 next_sak;
  logic                 busy;
  logic                 progDone;
  logic [PAGE_BYTES-1:0][7:0] pageData;
  logic [PAGE_BYTES-1:0]      pageFilled;
  logic                 ackEv;
  logic                 startPage;
  logic                 startStat;
  logic                 bufClear;
  logic                 bufWrite;
  logic [7:0]           liveStatus;

  // ****************************************************
  // helpers
  // ****************************************************
  // commands that touch the array or write the status byte are refused while busy
  function automatic logic cmdLegal(input logic [7:0] code, input logic isBusy);
    logic ok;
    ok = 1'b0;
    unique case (code)
      CMD_READ, CMD_CURRENT, CMD_WRITE, CMD_STAT_WR: ok = !isBusy;
      CMD_LATCH_SET, CMD_LATCH_CLR, CMD_STAT_RD:     ok = 1'b1;
      default:                                       ok = 1'b0;
    endcase
    return ok;
  endfunction

  // protect levels: none, upper quarter, upper half, whole array
  function automatic logic isProtected(input logic [7:0] addr, input logic [1:0] level);
    logic prot;
    prot = 1'b0;
    unique case (level)
      2'h0: prot = 1'b0;
      2'h1: prot = (addr >= PROT_QTR_BASE);
      2'h2: prot = (addr >= PROT_HALF_BASE);
      2'h3: prot = 1'b1;
    endcase
    return prot;
  endfunction

  // live status: busy and latch sampled each time a status byte goes out
  assign liveStatus = {4'h0, protectLevel, writeLatch, busy};

  assign ackEv     = ackIn.master_ack || ackIn.master_nack;
  // programming starts only on the closing nack and with the latch set
  assign startPage = (state == ST_WDATA) && ackIn.master_nack && !ackIn.standby
                     && writeLatch && !busy;
  assign startStat = (state == ST_SRDATA) && ackIn.master_nack && !ackIn.standby
                     && writeLatch && !busy;
  assign bufClear  = (state == ST_CMD) && ackIn.master_ack && (cmdReg == CMD_WRITE);
  assign bufWrite  = (state == ST_WDATA) && rxByte.valid;

  // ****************************************************
  // next state and acknowledge decision
  // ****************************************************
  always_comb begin
    next_state = state;
    next_sak   = 1'b0;
    if (ackIn.standby) begin
      next_state = ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (cmdStart) begin
            next_state = ST_CMD;
          end
        end
        ST_CMD: begin
          if (rxByte.valid && !cmdLegal(rxByte.data, busy)) begin
            next_state = ST_MUTE;
          end else if (ackEv) begin
            unique case (cmdReg)
              CMD_READ, CMD_WRITE: begin
                next_state = ackIn.master_ack ? ST_ADDRHI : ST_IDLE;
                next_sak   = ackIn.master_ack;
              end
              CMD_CURRENT: begin
                next_state = ackIn.master_ack ? ST_RDATA : ST_IDLE;
                next_sak   = ackIn.master_ack;
              end
              CMD_STAT_RD: begin
                next_state = ackIn.master_ack ? ST_STATUS : ST_IDLE;
                next_sak   = ackIn.master_ack;
              end
              CMD_STAT_WR: begin
                next_state = ackIn.master_ack ? ST_SRDATA : ST_IDLE;
                next_sak   = ackIn.master_ack;
              end
              CMD_LATCH_SET, CMD_LATCH_CLR: begin
                next_state = ackIn.master_ack ? ST_MUTE : ST_IDLE;
                next_sak   = ackIn.master_nack;
              end
              default: next_state = ST_MUTE;
            endcase
          end
        end
        ST_ADDRHI: begin
          if (ackEv) begin
            next_state = ackIn.master_ack ? ST_ADDRLO : ST_IDLE;
            next_sak   = ackIn.master_ack;
          end
        end
        ST_ADDRLO: begin
          if (ackEv) begin
            // a nack here means no data was sent: abort quietly
            if (ackIn.master_nack) begin
              next_state = ST_IDLE;
            end else begin
              next_state = (cmdReg == CMD_READ) ? ST_RDATA : ST_WDATA;
              next_sak   = 1'b1;
            end
          end
        end
        ST_RDATA, ST_WDATA, ST_STATUS: begin
          if (ackEv) begin
            next_state = ackIn.master_ack ? state : ST_IDLE;
            next_sak   = 1'b1;
          end
        end
        ST_SRDATA: begin
          if (ackEv) begin
            next_state = ackIn.master_ack ? ST_MUTE : ST_IDLE;
            next_sak   = ackIn.master_nack;
          end
        end
        ST_MUTE: next_state = ST_MUTE;     // only standby leaves
        default: next_state = ST_IDLE;
      endcase
    end
  end

  // ****************************************************
  // state register and handshake outputs
  // ****************************************************
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state   <= ST_IDLE;
      sakOut  <= 1'b0;
      muteOut <= 1'b0;
    end else begin
      state   <= next_state;
      sakOut  <= next_sak;
      muteOut <= (next_state == ST_MUTE);
    end
  end

  // latch the last received byte; command byte kept for the whole command
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rxData <= 8'h00;
      cmdReg <= 8'h00;
    end else if (rxByte.valid) begin
      rxData <= rxByte.data;
      if (state == ST_CMD) begin
        cmdReg <= rxByte.data;
      end
    end
  end

  // ****************************************************
  // internal address counter
  // ****************************************************
  // standby wins: no load or increment if it arrives instead of an ack
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      addrCount <= '0;
    end else if (!ackIn.standby) begin
      if ((state == ST_ADDRHI || state == ST_ADDRLO) && ackIn.master_ack) begin
        addrCount <= rxData;
      end else if (state == ST_RDATA && ackEv) begin
        addrCount <= addrCount + 8'h01;
      end else if (state == ST_WDATA && ackEv) begin
        addrCount <= {addrCount[7:4], addrCount[3:0] + 4'h1};
      end
    end
  end

  // ****************************************************
  // transmit path: array data or status byte
  // ****************************************************
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      txByte <= '0;
    end else begin
      txByte.valid <= 1'b0;
      if (!ackIn.standby && ackIn.master_ack) begin
        if (state == ST_ADDRLO && cmdReg == CMD_READ) begin
          txByte.valid <= 1'b1;
          txByte.data  <= mem[rxData];
        end else if (state == ST_CMD && cmdReg == CMD_CURRENT) begin
          txByte.valid <= 1'b1;
          txByte.data  <= mem[addrCount];
        end else if (state == ST_RDATA) begin
          txByte.valid <= 1'b1;
          txByte.data  <= mem[addrCount + 8'h01];
        end else if (state == ST_STATUS
                     || (state == ST_CMD && cmdReg == CMD_STAT_RD)) begin
          txByte.valid <= 1'b1;
          txByte.data  <= liveStatus;
        end
      end
    end
  end

  // status mirror for the outside world
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      statusOut <= 8'h00;
    end else begin
      statusOut <= liveStatus;
    end
  end

  // ****************************************************
  // write latch and protect bits
  // ****************************************************
  // completion clears the latch; a set command in the same cycle wins
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      writeLatch <= LATCH_RESET;
    end else if (state == ST_CMD && ackIn.master_nack && !ackIn.standby
                 && cmdReg == CMD_LATCH_SET) begin
      writeLatch <= 1'b1;
    end else if (state == ST_CMD && ackIn.master_nack && !ackIn.standby
                 && cmdReg == CMD_LATCH_CLR) begin
      writeLatch <= 1'b0;
    end else if (progDone) begin
      writeLatch <= 1'b0;
    end
  end

  // taken at the start so a status read during programming shows the new
  // value; no reset because these bits model nonvolatile cells
  always_ff @(posedge clock) begin
    if (startStat) begin
      protectLevel <= rxData[ST_PROT_LSB +: 2];
    end
  end

  // what kind of cycle is running and which page it targets
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      progIsPage <= 1'b0;
      pageBase   <= 4'h0;
    end else if (startPage || startStat) begin
      progIsPage <= startPage;
      pageBase   <= addrCount[7:4];
    end
  end

  // ****************************************************
  // array commit at the end of a page cycle
  // ****************************************************
  // only filled slots outside the protected range are written
  always_ff @(posedge clock) begin
    if (progDone && progIsPage) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (pageFilled[i]
            && !isProtected({pageBase, PAGE_IDX_W'(i)}, protectLevel)) begin
          mem[{pageBase, PAGE_IDX_W'(i)}] <= pageData[i];
        end
      end
    end
  end

  // ****************************************************
  // submodules
  // ****************************************************
  scm_page_buffer #(
    .DEPTH (PAGE_BYTES),
    .WIDTH (8)
  ) u_page (
    .clock   (clock),
    .rst_b   (rst_b),
    .clear   (bufClear),
    .set_write_latch_cmd    (bufWrite),
    .wrIdx   (addrCount[3:0]),
    .wrData  (rxByte.data),
    .entries (pageData),
    .filled  (pageFilled)
  );

  scm_prog_timer #(
    .CYCLES (PROG_CYC)
  ) u_timer (
    .clock (clock),
    .rst_b (rst_b),
    .start (startPage || startStat),
    .busy  (busy),
    .done  (progDone)
  );
endmodule // scm_core
`default_nettype wire

// ### rtl/scm_pkg.sv
// constants, carrier structs and state codes for the serial memory command core
// assumes a byte framer on the same clock that decodes the single-wire line
package scm_pkg;
  // ****************************************************
  // array geometry and command codes
  // ****************************************************
  localparam int          ADDR_W        = 8;
  localparam int          PAGE_BYTES    = 16;
  localparam int          PAGE_IDX_W    = 4;
  localparam logic [7:0]  CMD_READ      = 8'h03;
  localparam logic [7:0]  CMD_CURRENT   = 8'h06;
  localparam logic [7:0]  CMD_WRITE     = 8'h6C;
  localparam logic [7:0]  CMD_LATCH_SET = 8'h96;
  localparam logic [7:0]  CMD_LATCH_CLR = 8'h91;
  localparam logic [7:0]  CMD_STAT_RD   = 8'h05;
  localparam logic [7:0]  CMD_STAT_WR   = 8'h6E;
  // ****************************************************
  // status byte fields, protection and reset values
  // ****************************************************
  localparam int          ST_BUSY_BIT   = 0;
  localparam int          ST_LATCH_BIT  = 1;
  localparam int          ST_PROT_LSB   = 2;
  localparam logic [7:0]  PROT_QTR_BASE = 8'hC0;
  localparam logic [7:0]  PROT_HALF_BASE = 8'h80;
  localparam logic [1:0]  PROT_INIT     = 2'h1;
  localparam logic        LATCH_RESET   = 1'b0;
  // ****************************************************
  // self-timed programming
  // ****************************************************
  localparam int          CLOCK_HZ      = 25000000;
  localparam int          PROG_TIME_US  = 5;
  localparam int          PROG_CYCLES   = PROG_TIME_US * (CLOCK_HZ / 1000000);

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } scm_byte_type;

  typedef struct packed {
    logic master_ack;
    logic master_nack;
    logic standby;
  } scm_ack_type;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_CMD    = 4'h1,
    ST_ADDRHI = 4'h3,
    ST_ADDRLO = 4'h2,
    ST_RDATA  = 4'h6,
    ST_WDATA  = 4'h7,
    ST_STATUS = 4'h5,
    ST_SRDATA = 4'h4,
    ST_MUTE   = 4'hC
  } scm_state_type;
endpackage

// ### rtl/scm_prog_timer.sv
// self-timed programming cycle: busy from start until the count runs out
// assumes start only arrives while not busy
`timescale 1ns/10ps
`default_nettype none
module scm_prog_timer #(
  parameter int CYCLES = 125000
) (
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic start,
  output logic      busy,
  output logic      done
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] count;

  // ****************************************************
  // count up to LAST; done is a one-cycle pulse as busy drops
  // ****************************************************
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      busy  <= 1'b0;
      done  <= 1'b0;
      count <= '0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy  <= 1'b1;
        count <= '0;
      end else if (busy) begin
        if (count == LAST) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count + CW'(1);
        end
      end
    end
  end
endmodule // scm_prog_timer
`default_nettype wire

// ### rtl/scm_page_buffer.sv
// page buffer: one slot per byte of a page plus a filled mask
// assumes clear and write never fall in the same cycle
`timescale 1ns/10ps
`default_nettype none
module scm_page_buffer #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 8
) (
  input  wire logic                           clock,
  input  wire logic                           rst_b,
  input  wire logic                           clear,
  input  wire logic                           set_write_latch_cmd,
  input  wire logic [$clog2(DEPTH)-1:0]       wrIdx,
  input  wire logic [WIDTH-1:0]               wrData,
  output logic      [DEPTH-1:0][WIDTH-1:0]    entries,
  output logic      [DEPTH-1:0]               filled
);
  // ****************************************************
  // storage; a later byte to the same slot replaces it
  // ****************************************************
  always_ff @(posedge clock) begin
    if (set_write_latch_cmd) begin
      entries[wrIdx] <= wrData;
    end
  end

  // slot mask, cleared per command so stale bytes never program
  always_ff @(posedge clock) begin
    if (!rst_b || clear) begin
      filled <= '0;
    end else if (set_write_latch_cmd) begin
      filled[wrIdx] <= 1'b1;
    end
  end
endmodule // scm_page_buffer
`default_nettype wire

// ### test/scm_core_asserts.sv
// checker for the command core: stream, mute and status relations
// assumes it is bound to scm_core and sees only its ports
`timescale 1ns/10ps
`default_nettype none
module scm_core_asserts
  import scm_pkg::*;
#(
  parameter int PROG_CYC = 20
) (
  input wire logic         clock,
  input wire logic         rst_b,
  input wire logic         cmdStart,
  input wire scm_byte_type rxByte,
  input wire scm_ack_type  ackIn,
  input wire scm_byte_type txByte,
  input wire logic         sakOut,
  input wire logic         muteOut,
  input wire logic [7:0]   statusOut
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  int busyRun;
  // length of the current busy run, read when busy falls
  always_ff @(posedge clock) begin
    if (!rst_b || !statusOut[0]) busyRun <= 0;
    else busyRun <= busyRun + 1;
  end
  // ****************************************************
  // sequences
  // ****************************************************
  sequence bad_cmd_s;
    cmdStart ##1 (rxByte.valid && rxByte.data == 8'h6D);
  endsequence
  sequence any_nack_s;
    $past(ackIn.master_nack, 1) || $past(ackIn.master_nack, 2) || $past(ackIn.master_nack, 3);
  endsequence
  // ****************************************************
  // assertions
  // ****************************************************
  chk_status_upper_zero: assert property (statusOut[7:4] == 4'h0)
    else $error("status upper nibble not zero");
  chk_sak_after_ack: assert property (sakOut |-> $past(ackIn.master_ack | ackIn.master_nack))
    else $error("slave ack without master ack event");
  chk_tx_after_mak: assert property (txByte.valid |-> $past(ackIn.master_ack))
    else $error("byte sent without master ack");
  chk_busy_start: assert property ($rose(statusOut[0]) |-> $past(ackIn.master_nack, 2))
    else $error("busy rose without terminating nack");
  chk_busy_length: assert property ($fell(statusOut[0]) |-> busyRun >= PROG_CYC - 2)
    else $error("busy ended early");
  chk_mute_holds: assert property (muteOut && !ackIn.standby |=> muteOut)
    else $error("mute dropped without standby");
  chk_bad_cmd_mute: assert property (bad_cmd_s |=> muteOut ##1 !sakOut)
    else $error("unknown command not muted");
  chk_latch_source: assert property ($rose(statusOut[1]) |-> any_nack_s)
    else $error("latch set without terminated command");
endmodule // scm_core_asserts
`default_nettype wire

// ### test/scm_host_model.sv
// host side model: drives command, byte and ack pulses toward the core
// assumes the bench calls its tasks one at a time
`timescale 1ns/10ps
`default_nettype none
module scm_host_model
  import scm_pkg::*;
(
  input  wire logic        clock,
  output var logic         cmdStart,
  output var scm_byte_type rxByte,
  output var scm_ack_type  ackIn
);
  initial begin
    cmdStart = 1'b0;
    rxByte   = '0;
    ackIn    = '0;
  end
  // address match pulse, command byte in the very next cycle
  task automatic send_cmd(input logic [7:0] code);
    @(posedge clock); #1;
    cmdStart = 1'b1;
    @(posedge clock); #1;
    cmdStart = 1'b0;
    rxByte   = '{1'b1, code};
    @(posedge clock); #1;
    rxByte   = '{1'b0, ~code}; // released line never shows a stale byte
  endtask
  // one byte pulse; a gap cycle always follows before the ack
  task automatic send_byte(input logic [7:0] b);
    @(posedge clock); #1;
    rxByte = '{1'b1, b};
    @(posedge clock); #1;
    rxByte = '{1'b0, ~b};
  endtask
  // kind 0 master_ack, 1 master_nack, 2 standby pulse
  task automatic send_ack(input int kind);
    @(posedge clock); #1;
    ackIn = '{kind == 0, kind == 1, kind == 2};
    @(posedge clock); #1;
    ackIn = '0;
  endtask
endmodule // scm_host_model
`default_nettype wire

// ### test/scm_core_tb_top.sv
// self-checking bench for the command core with a host model in front
// assumes a short programming count so each write settles quickly
`timescale 1ns/10ps
`default_nettype none
module scm_core_tb_top;
  import scm_pkg::*;
  localparam int PC = 20;
  logic         clock;
  logic         rst_b;
  logic         cmdStart;
  scm_byte_type rxByte;
  scm_ack_type  ackIn;
  scm_byte_type txByte;
  logic         sakOut;
  logic         muteOut;
  logic [7:0]   statusOut;
  int           errors;
  int           tests_run;
  int           cycles;
  scm_core #(
    .PROG_CYC  (PC)
  ) u_scm_core (
    .clock     (clock),
    .rst_b     (rst_b),
    .cmdStart  (cmdStart),
    .rxByte    (rxByte),
    .ackIn     (ackIn),
    .txByte    (txByte),
    .sakOut    (sakOut),
    .muteOut   (muteOut),
    .statusOut (statusOut)
  );
  scm_host_model u_scm_host_model (
    .clock     (clock),
    .cmdStart  (cmdStart),
    .rxByte    (rxByte),
    .ackIn     (ackIn)
  );
  // ****************************************************
  // shared helpers
  // ****************************************************
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    if (errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cmd_ack(input logic [7:0] code, input int kind);
    u_scm_host_model.send_cmd(code);
    u_scm_host_model.send_ack(kind);
  endtask
  task automatic addr(input logic [7:0] a);
    u_scm_host_model.send_byte(8'h00);
    u_scm_host_model.send_ack(0);
    u_scm_host_model.send_byte(a);
    u_scm_host_model.send_ack(0);
  endtask
  task automatic page_write(input logic [7:0] a, input logic [7:0] d[$]);
    cmd_ack(CMD_WRITE, 0);
    addr(a);
    foreach (d[i]) begin
      u_scm_host_model.send_byte(d[i]);
      u_scm_host_model.send_ack(i == d.size() - 1);
    end
  endtask
  // repeated status polling until the busy bit clears
  task automatic wait_idle();
    int n;
    cmd_ack(CMD_STAT_RD, 0);
    for (n = 0; n < 60 && txByte.data[0] !== 1'b0; n++) u_scm_host_model.send_ack(0);
    check("poll busy", {7'h00, txByte.data[0]}, 8'h00);
    u_scm_host_model.send_ack(1);
  endtask
  task automatic read_at(input logic [7:0] a, input logic [7:0] exp);
    cmd_ack(CMD_READ, 0);
    addr(a);
    check("read valid", {7'h00, txByte.valid}, 8'h01);
    check("read data", txByte.data, exp);
    u_scm_host_model.send_ack(1);
  endtask
  task automatic settle();
    @(posedge clock); #1;
  endtask
  // ****************************************************
  // scenarios
  // ****************************************************
  task automatic t_latch();
    check("power-up status", statusOut, 8'h04);
    cmd_ack(CMD_LATCH_SET, 1);
    check("set sak", {7'h00, sakOut}, 8'h01);
    settle();
    check("latch set", statusOut, 8'h06);
    cmd_ack(CMD_LATCH_CLR, 1);
    settle();
    check("latch clr", statusOut, 8'h04);
    cmd_ack(CMD_LATCH_SET, 0);
    check("mak sak", {7'h00, sakOut}, 8'h00);
    check("mak mute", {7'h00, muteOut}, 8'h01);
    u_scm_host_model.send_ack(2);
    check("mak no set", statusOut, 8'h04);
  endtask
  task automatic t_page();
    cmd_ack(CMD_LATCH_SET, 1);
    page_write(8'h3F, '{8'hA1, 8'hA2, 8'hA3});
    check("write sak", {7'h00, sakOut}, 8'h01);
    settle();
    check("busy status", statusOut, 8'h07);
    u_scm_host_model.send_cmd(CMD_WRITE);
    check("busy mute", {7'h00, muteOut}, 8'h01);
    u_scm_host_model.send_ack(2);
    cmd_ack(CMD_STAT_RD, 0);
    check("status in busy", txByte.data, 8'h07);
    u_scm_host_model.send_ack(1);
    wait_idle();
    check("latch after write", statusOut, 8'h04);
    read_at(8'h3F, 8'hA1);
    cmd_ack(CMD_READ, 0);
    addr(8'h30);
    check("wrap byte", txByte.data, 8'hA2);
    u_scm_host_model.send_ack(0);
    check("next byte", txByte.data, 8'hA3);
    u_scm_host_model.send_ack(2);
    cmd_ack(CMD_CURRENT, 0);
    check("current read", txByte.data, 8'hA3);
    u_scm_host_model.send_ack(1);
    check("current sak", {7'h00, sakOut}, 8'h01);
  endtask
  task automatic t_abort();
    page_write(8'h30, '{8'hEE});
    wait_idle();
    read_at(8'h30, 8'hA2);
    cmd_ack(CMD_LATCH_SET, 1);
    cmd_ack(CMD_WRITE, 0);
    addr(8'h30);
    u_scm_host_model.send_byte(8'h77);
    u_scm_host_model.send_ack(2);
    settle();
    check("standby abort", statusOut, 8'h06);
    cmd_ack(CMD_WRITE, 0);
    u_scm_host_model.send_byte(8'h00);
    u_scm_host_model.send_ack(0);
    u_scm_host_model.send_byte(8'h30);
    u_scm_host_model.send_ack(1);
    check("early nack", {6'h00, sakOut, statusOut[0]}, 8'h00);
    read_at(8'h30, 8'hA2);
  endtask
  task automatic write_status_cmd(input logic [7:0] v);
    cmd_ack(CMD_LATCH_SET, 1);
    cmd_ack(CMD_STAT_WR, 0);
    u_scm_host_model.send_byte(v);
    u_scm_host_model.send_ack(1);
  endtask
  task automatic t_protect();
    write_status_cmd(8'h00);
    cmd_ack(CMD_STAT_RD, 0);
    check("new protect", {4'h0, txByte.data[3:2], 1'b0, txByte.data[0]}, 8'h01);
    u_scm_host_model.send_ack(1);
    wait_idle();
    cmd_ack(CMD_LATCH_SET, 1);
    page_write(8'hC0, '{8'h5A});
    wait_idle();
    write_status_cmd(8'h04);
    wait_idle();
    check("protect back", statusOut, 8'h04);
    cmd_ack(CMD_LATCH_SET, 1);
    page_write(8'hC0, '{8'hA5});
    wait_idle();
    read_at(8'hC0, 8'h5A);
    u_scm_host_model.send_cmd(8'h6D);
    check("bad cmd mute", {7'h00, muteOut}, 8'h01);
    u_scm_host_model.send_ack(2);
  endtask
  // ****************************************************
  // clock, reset, watchdog and main sequence
  // ****************************************************
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // a hang past the expected run length counts as a failure
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      close_out();
    end
  end
  initial begin
    errors    = 0;
    tests_run = 0;
    cycles    = 0;
    rst_b     = 1'b0;
    repeat (3) @(posedge clock);
    #1;
    rst_b = 1'b1;
    repeat (2) settle();
    t_latch();
    t_page();
    t_abort();
    t_protect();
    close_out();
  end
endmodule // scm_core_tb_top
bind scm_core scm_core_asserts #(
  .PROG_CYC  (PROG_CYC)
) u_scm_core_asserts (
  .clock     (clock),
  .rst_b     (rst_b),
  .cmdStart  (cmdStart),
  .rxByte    (rxByte),
  .ackIn     (ackIn),
  .txByte    (txByte),
  .sakOut    (sakOut),
  .muteOut   (muteOut),
  .statusOut (statusOut)
);
`default_nettype wire
